/* File: logic/lpc_compressor.sv */
`timescale 1ns/1ns
module lpc_compressor (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sampleValid,
  input  wire logic [13:0] linearSampleIn,
  output logic             codeValid,
  output logic      [7:0]  logCodeOut
);
  import lpc_pkg::*;

  logic        lawSelect;
  logic        next_lawSelect;
  logic        codeSeen;
  logic        next_codeSeen;
  logic        wrPend;
  logic        next_wrPend;
  logic [31:0] wrAddr;
  logic [31:0] next_wrAddr;
  logic [31:0] next_hrdata;
  logic        next_codeValid;
  logic [7:0]  next_logCodeOut;
  logic        busTake;
  logic        negIn;
  logic [15:0] sampleExt;
  logic [15:0] sampleMagnitude;
  logic [15:0] biasedMag;
  logic [3:0]  leadPos;
  logic [4:0]  segment;
  logic [3:0]  mantissa;
  logic [6:0]  magCode;
  logic [7:0]  signedCode;
  logic [15:0] companding_bias;
  logic [4:0]  segment_constant;
  logic [7:0]  output_inversion_mask;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign busTake   = hsel && htrans[1] && hready;

  // Bus next-state: write capture and read data
  always_comb begin
    next_lawSelect = lawSelect;
    next_wrPend    = busTake && hwrite;
    next_wrAddr    = busTake ? haddr : wrAddr;
    next_hrdata    = hrdata;
    if (wrPend && wrAddr == ADDR_CTRL) begin
      next_lawSelect = hwdata[CTRL_LAW];
    end
    if (busTake && !hwrite) begin
      unique case (haddr)
        ADDR_CTRL: next_hrdata = {31'h0000_0000, lawSelect};
        ADDR_CODE: next_hrdata = {23'h00_0000, codeSeen, logCodeOut};
        ADDR_MASK: next_hrdata = {24'h00_0000, output_inversion_mask};
        default:   next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Law-dependent constants
  always_comb begin
    if (lawSelect == LAW_A) begin
      companding_bias       = A_BIAS;
      segment_constant      = A_SEG_OFS - A_SEG_COMP;
      output_inversion_mask = A_MASK;
    end else begin
      companding_bias       = MU_BIAS;
      segment_constant      = MU_SEG_OFS;
      output_inversion_mask = MU_MASK;
    end
  end

  // Magnitude, shift and bias
  always_comb begin
    negIn     = linearSampleIn[13];
    sampleExt = {{2{linearSampleIn[13]}}, linearSampleIn};
    sampleMagnitude = (negIn ? (16'h0000 - sampleExt) : sampleExt) & MAG_MASK;
    if (lawSelect == LAW_A) begin
      if (negIn) begin
        sampleMagnitude = sampleMagnitude - 16'h0001;
      end
      sampleMagnitude = sampleMagnitude >> A_SHIFT;
    end
    biasedMag = sampleMagnitude + companding_bias;
  end

  // Leading one, segment and mantissa
  always_comb begin
    leadPos = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (biasedMag[i]) begin
        leadPos = 4'(i);
      end
    end
    // Exponent is leadPos+1; segment drops one and the offset
    segment  = 5'({1'b0, leadPos}) - segment_constant;
    mantissa = 4'(biasedMag >> (5'({1'b0, leadPos}) - MANT_BITS));
    if (biasedMag < LIN_LIMIT) begin
      magCode = biasedMag[6:0];
    end else if (segment > SEG_MAX) begin
      magCode = CODE_MAX;
    end else begin
      magCode = {segment[2:0], mantissa};
    end
    signedCode = {1'b0, magCode} + (negIn ? 8'h00 : SIGN_ADD);
  end

  // Output stage next values
  always_comb begin
    next_codeValid  = sampleValid;
    next_logCodeOut = logCodeOut;
    next_codeSeen   = codeSeen || sampleValid;
    if (sampleValid) begin
      next_logCodeOut = signedCode ^ output_inversion_mask;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lawSelect  <= LAW_RESET;
      codeSeen   <= 1'b0;
      wrPend     <= 1'b0;
      wrAddr     <= 32'h0000_0000;
      hrdata     <= 32'h0000_0000;
      codeValid  <= 1'b0;
      logCodeOut <= CODE_RESET;
    end else begin
      lawSelect  <= next_lawSelect;
      codeSeen   <= next_codeSeen;
      wrPend     <= next_wrPend;
      wrAddr     <= next_wrAddr;
      hrdata     <= next_hrdata;
      codeValid  <= next_codeValid;
      logCodeOut <= next_logCodeOut;
    end
  end

  // Checks
  chk_strobe_latency: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid |=> codeValid) else $error("code strobe missing");
  chk_strobe_pulse: assert property (@(posedge clk) disable iff (!resetn)
    !sampleValid |=> !codeValid) else $error("spurious code strobe");
  chk_code_held: assert property (@(posedge clk) disable iff (!resetn)
    !codeValid ##1 !codeValid |-> $stable(logCodeOut)) else $error("code changed");
  chk_sign_bit: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid |=> logCodeOut[7] == !$past(linearSampleIn[13]))
    else $error("sign bit wrong");
  chk_mu_zero: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && linearSampleIn == 14'h0000
    |=> logCodeOut == 8'hff) else $error("mu zero code wrong");
  chk_a_zero: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && linearSampleIn == 14'h0000
    |=> logCodeOut == 8'hd5) else $error("A zero code wrong");
  chk_a_round: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && linearSampleIn == 14'h3ffc
    |=> logCodeOut == 8'h55) else $error("A negative rounding wrong");
  chk_a_linear: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && linearSampleIn[13:7] == 7'h00
    |=> logCodeOut == ((8'h80 | 8'($past(linearSampleIn) >> 2)) ^ 8'h55))
    else $error("A linear range wrong");
  chk_mu_segment: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && linearSampleIn == 14'h001f
    |=> logCodeOut == 8'hef) else $error("mu segment wrong");
  chk_mu_saturate: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && linearSampleIn == 14'h1fff
    |=> logCodeOut == 8'h80) else $error("mu saturation wrong");
  chk_most_negative: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && linearSampleIn == 14'h2000
    |=> logCodeOut == 8'h00) else $error("most negative wrong");
  chk_law_write: assert property (@(posedge clk) disable iff (!resetn)
    busTake && hwrite && haddr == ADDR_CTRL ##1 1'b1
    |=> lawSelect == $past(hwdata[CTRL_LAW])) else $error("law write lost");

  // Bus side: answer, readback and law register upkeep
  chk_bus_answer: assert property (@(posedge clk) disable iff (!resetn)
    hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_read_ctrl: assert property (@(posedge clk) disable iff (!resetn)
    busTake && !hwrite && haddr == ADDR_CTRL
    |=> hrdata == {31'h0000_0000, $past(lawSelect)})
    else $error("law readback wrong");
  chk_read_mask: assert property (@(posedge clk) disable iff (!resetn)
    busTake && !hwrite && haddr == ADDR_MASK
    |=> hrdata == {24'h00_0000, (($past(lawSelect) == LAW_A) ? A_MASK : MU_MASK)})
    else $error("mask readback wrong");
  chk_read_code: assert property (@(posedge clk) disable iff (!resetn)
    busTake && !hwrite && haddr == ADDR_CODE
    |=> hrdata == {23'h00_0000, $past(codeSeen), $past(logCodeOut)})
    else $error("code readback wrong");
  chk_hrdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(busTake && !hwrite)
    |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_stray_write: assert property (@(posedge clk) disable iff (!resetn)
    busTake && hwrite && haddr != ADDR_CTRL ##1 1'b1
    |=> $stable(lawSelect))
    else $error("law changed by a stray write");
  chk_law_stable: assert property (@(posedge clk) disable iff (!resetn)
    !(wrPend && wrAddr == ADDR_CTRL)
    |=> $stable(lawSelect))
    else $error("law changed without a write");

  // Magnitude: absolute value, A-law rounding and shift
  chk_mu_abs_pos: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && !linearSampleIn[13]
    |-> sampleMagnitude == {2'b00, linearSampleIn})
    else $error("positive magnitude wrong");
  chk_mu_abs_neg: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && linearSampleIn[13]
    |-> sampleMagnitude[15:14] == 2'b00 && 14'(sampleMagnitude[13:0] + linearSampleIn) == 14'h0000)
    else $error("negative magnitude wrong");
  chk_a_shift_pos: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && !linearSampleIn[13]
    |-> sampleMagnitude == {4'h0, linearSampleIn[13:2]})
    else $error("A-law shift wrong");
  chk_a_round_neg: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && linearSampleIn[13]
    |-> sampleMagnitude == {4'h0, ~linearSampleIn[13:2]})
    else $error("A-law negative rounding wrong");

  // Bias and the linear range
  chk_mu_bias: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU
    |-> biasedMag == sampleMagnitude + 16'h0021)
    else $error("mu-law bias wrong");
  chk_a_bias: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A
    |-> biasedMag == sampleMagnitude)
    else $error("A-law bias wrong");
  chk_linear_path: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && biasedMag < 16'h0020
    |=> logCodeOut[6:0] == ($past(biasedMag[6:0]) ^ 7'h55))
    else $error("linear range code wrong");

  // Leading one, mantissa and segment bands
  chk_lead_one: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && biasedMag >= 16'h0020
    |-> (biasedMag >> leadPos) == 16'h0001)
    else $error("leading one misplaced");
  chk_mantissa_bits: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && biasedMag >= 16'h0020
    |-> (biasedMag >> (leadPos - 4'h4)) == {12'h001, mantissa})
    else $error("mantissa bits wrong");
  chk_mu_band: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && segment <= SEG_MAX
    |-> biasedMag >= (16'h0020 << segment) && biasedMag < (16'h0040 << segment))
    else $error("mu-law segment band wrong");
  chk_a_band: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A && biasedMag >= LIN_LIMIT
    |-> biasedMag >= (16'h0008 << segment) && biasedMag < (16'h0010 << segment))
    else $error("A-law segment band wrong");

  // Saturation, sign and inversion mask
  chk_mu_clip: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU && biasedMag >= 16'h2000
    |=> logCodeOut[6:0] == 7'h00)
    else $error("mu-law clipping wrong");
  chk_sign_add: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid
    |-> signedCode == {!linearSampleIn[13], magCode})
    else $error("sign bit placement wrong");
  chk_mu_mask: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU
    |=> logCodeOut[6:0] == ~$past(magCode))
    else $error("mu-law inversion wrong");
  chk_a_mask: assert property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A
    |=> logCodeOut[6:0] == ($past(magCode) ^ 7'h55))
    else $error("A-law inversion wrong");

  // Code-seen flag and idle output
  chk_seen_flag: assert property (@(posedge clk) disable iff (!resetn)
    codeValid
    |-> codeSeen)
    else $error("seen flag missing");
  chk_idle_code: assert property (@(posedge clk) disable iff (!resetn)
    !codeSeen
    |-> logCodeOut == CODE_RESET && !codeValid)
    else $error("code moved before any sample");

  cov_mu_sample: cover property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_MU ##1 codeValid);
  cov_a_sample: cover property (@(posedge clk) disable iff (!resetn)
    sampleValid && lawSelect == LAW_A ##1 codeValid);
  cov_saturate: cover property (@(posedge clk) disable iff (!resetn)
    sampleValid && magCode == CODE_MAX);
  cov_back_to_back: cover property (@(posedge clk) disable iff (!resetn)
    sampleValid [*3]);
  cov_law_change: cover property (@(posedge clk) disable iff (!resetn)
    wrPend && wrAddr == ADDR_CTRL ##1 $changed(lawSelect));
endmodule : lpc_compressor

/* File: logic/lpc_pkg.sv */
package lpc_pkg;
  // Register byte addresses and bit positions
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_CODE   = 32'h0000_0004;
  localparam logic [31:0] ADDR_MASK   = 32'h0000_000c;
  localparam int          CTRL_LAW    = 0;
  localparam int          CODE_SEEN   = 8;
  // Law encodings and reset values
  localparam logic        LAW_MU      = 1'b0;
  localparam logic        LAW_A       = 1'b1;
  localparam logic        LAW_RESET   = 1'b0;
  localparam logic [7:0]  CODE_RESET  = 8'h00;
  // Companding constants
  localparam logic [15:0] MU_BIAS     = 16'h0021;
  localparam logic [15:0] A_BIAS      = 16'h0000;
  localparam logic [15:0] MAG_MASK    = 16'h7fff;
  localparam logic [15:0] LIN_LIMIT   = 16'h0020;
  localparam int          A_SHIFT     = 2;
  localparam logic [4:0]  MU_SEG_OFS  = 5'h05;
  localparam logic [4:0]  A_SEG_OFS   = 5'h04;
  localparam logic [4:0]  A_SEG_COMP  = 5'h01;
  localparam logic [4:0]  SEG_MAX     = 5'h07;
  localparam logic [4:0]  MANT_BITS   = 5'h04;
  localparam logic [6:0]  CODE_MAX    = 7'h7f;
  localparam logic [7:0]  SIGN_ADD    = 8'h80;
  localparam logic [7:0]  MU_MASK     = 8'h7f;
  localparam logic [7:0]  A_MASK      = 8'h55;
endpackage : lpc_pkg

/* File: tb/lpc_sample_src.sv */
`timescale 1ns/1ns
module lpc_sample_src (
  input  wire logic        clk,
  output logic             sampleValid,
  output logic      [13:0] linearSampleIn
);
  // Idle at time zero
  initial begin
    sampleValid    = 1'b0;
    linearSampleIn = 14'h0000;
  end
  // One sample per edge; back to back when called again at once
  task send(input logic [13:0] s);
    @(posedge clk);
    sampleValid    <= 1'b1;
    linearSampleIn <= s;
  endtask : send
  // Strobe released; data lines invert on each idle edge
  task pause(input int n);
    repeat (n) begin
      @(posedge clk);
      sampleValid    <= 1'b0;
      linearSampleIn <= ~linearSampleIn;
    end
  endtask : pause
endmodule : lpc_sample_src

/* File: tb/tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errCount++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
  import lpc_pkg::*;
  logic        clk = 1'b0;
  logic        resetn, hsel, hwrite, hreadyout, hresp, sampleValid, codeValid, law;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [13:0] linearSampleIn;
  logic [7:0]  logCodeOut, lastCode;
  logic [8:0]  pend;
  int          errCount = 0;
  int          checked = 0;
  logic [13:0] smp [12] = '{14'h0000, 14'h001f, 14'h3fff, 14'h1fff, 14'h2000, 14'h003f,
                            14'h3ffc, 14'h0064, 14'h3f9c, 14'h0fff, 14'h0040, 14'h3fdf};
  // Clock, 40 ns period
  always #20 clk = ~clk;
  lpc_sample_src src (.clk(clk), .sampleValid(sampleValid), .linearSampleIn(linearSampleIn));
  lpc_compressor DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sampleValid(sampleValid),
    .linearSampleIn(linearSampleIn), .codeValid(codeValid), .logCodeOut(logCodeOut));
  // Reference compression of one sample
  function automatic logic [7:0] refCode(input logic lw, input logic [13:0] s);
    logic [15:0] m;
    int          e;
    int          seg;
    logic [6:0]  c;
    m = {{2{s[13]}}, s};
    if (s[13]) m = -m;
    m = m & 16'h7fff;
    if (lw) m = (m - {15'h0, s[13]}) >> 2;
    else m = m + 16'h0021;
    c = m[6:0];
    if (m >= 16'h0020) begin
      e = 15;
      while (!m[e]) e--;
      seg = e - (lw ? 4 - 1 : 5); // Leading one is exponent less one
      c = (seg > 7) ? 7'h7f : {seg[2:0], m[e-1 -: 4]};
    end
    return {~s[13], c} ^ (lw ? 8'h55 : 8'h7f);
  endfunction : refCode
  // One single AHB-Lite transfer
  task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task results();
    $display("Comparisons %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Code stream monitor: latency one, value, hold
  always @(posedge clk) begin
    if (resetn) begin
      `CHK(codeValid, pend[8])
      `CHK(logCodeOut, pend[8] ? pend[7:0] : lastCode)
      if (pend[8]) lastCode = pend[7:0];
      pend = {sampleValid, refCode(law, linearSampleIn)};
    end
  end
  // Watchdog
  initial begin
    #(40 * 4000);
    errCount++;
    results();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = {4'h0, 64'h0, 3'b010};
    {pend, lastCode, law} = {9'h0, CODE_RESET, LAW_RESET};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    ahb(ADDR_CTRL, 1'b0, 32'h0);
    `CHK(rd, {31'h0, LAW_RESET})
    ahb(32'h0000_0008, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    ahb(ADDR_CODE, 1'b0, 32'h0);
    `CHK(rd, {24'h0, CODE_RESET})
    ahb(ADDR_MASK, 1'b0, 32'h0);
    `CHK(rd, 32'h0000_007f)
    `CHK(hresp, 1'b0)
    $display("Test reset done");
    for (int l = 0; l < 2; l++) begin
      law = l[0];
      ahb(ADDR_CTRL, 1'b1, {31'h0, law});
      ahb(ADDR_CTRL, 1'b0, 32'h0);
      `CHK(rd, {31'h0, law})
      ahb(ADDR_MASK, 1'b0, 32'h0);
      `CHK(rd, {24'h0, law ? 8'h55 : 8'h7f})
      foreach (smp[i]) src.send(smp[i]);
      src.pause(2);
      src.send(14'h1000);
      src.pause(3);
      ahb(ADDR_CODE, 1'b0, 32'h0);
      `CHK(rd, {23'h0, 1'b1, refCode(law, 14'h1000)})
      $display("Test law %0d done", l);
    end
    ahb(32'h0000_0008, 1'b1, 32'h0);
    ahb(ADDR_CTRL, 1'b0, 32'h0);
    `CHK(rd, {31'h0, law})
    $display("Test stray write done");
    results();
  end
endmodule : tb
